// ===== logic/evt_pkg.sv
// constants of the event, status and mask unit and its serial register port
// assumes a single 20 MHz clock domain; shared by the core and the serial slave
package evt_pkg;

  // register offsets as seen over the two-wire port
  localparam logic [7:0] ADDR_EVENT = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_MASK = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_CONF = 8'hA5;

  // flag positions, shared by event, status and mask registers; polarity bit of the interrupt config
  localparam int BIT_SIGNAL_LOST = 0;
  localparam int BIT_FREQ_WINDOW = 1;
  localparam int BIT_OVER_TEMP = 2;
  localparam int BIT_SYNTH_UNLOCKED = 3;
  localparam int BIT_FIFO_SLIP = 7;
  localparam int BIT_IRQ_POLARITY = 0;
  localparam logic [7:0] FLAG_BITS = 8'h8F;

  // reset values
  localparam logic [7:0] MASK_RESET = 8'h04;
  localparam logic [7:0] IRQ_CONF_RESET = 8'h01;
  localparam logic IRQ_RESET_LEVEL = 1'b1;

  // write-only configuration bytes handed to the transmit path
  localparam int CFG_COUNT = 12;
  localparam logic [7:0] CFG_ADDR [CFG_COUNT] = '{
    8'hD5, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4,
    8'hE5, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4};
  localparam logic [7:0] CFG_RESET [CFG_COUNT] = '{
    8'h20, 8'h00, 8'h01, 8'h00, 8'h80, 8'h00,
    8'h00, 8'h62, 8'h02, 8'hA8, 8'h4B, 8'h03};

  // serial slave
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A; // arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ACK_ADDR = 4'b0010,
    ST_REG = 4'b0011,
    ST_ACK_REG = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_ACK_WDATA = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_MASTER_ACK = 4'b1000
  } slave_state_t;

endpackage : evt_pkg

// ===== logic/reg_port_if.sv
// register access carrier between the serial slave and the event core
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface reg_port_if;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_stb;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  modport slave (output wr_stb, output wr_addr, output wr_data,
                 output rd_stb, output rd_addr, input rd_data);
  modport core (input wr_stb, input wr_addr, input wr_data,
                input rd_stb, input rd_addr, output rd_data);
endinterface : reg_port_if

// ===== logic/serial_reg_slave.sv
// two-wire register slave: one byte write per transfer, reads stream 00h, 01h
// assumes scl, sda and chip select come straight from pins, unsynchronised
`timescale 1ns/10ps
module serial_reg_slave
  import evt_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic cs_i,
  output logic sda_oe_n_o,
  reg_port_if.slave port
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds stage two only
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic [2:0] pin_d_r;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_s1_r <= 3'h7;
      pin_s2_r <= 3'h7;
      pin_d_r <= 3'h7;
    end
    else
    begin
      pin_s1_r <= {cs_i, sda_i, scl_i};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  logic scl, sda, cs, scl_rise, scl_fall, start_cond, stop_cond;
  assign scl = pin_s2_r[0];
  assign sda = pin_s2_r[1];
  assign cs = pin_s2_r[2];
  assign scl_rise = scl & ~pin_d_r[0];
  assign scl_fall = ~scl & pin_d_r[0];
  // line changes with clock high mark start and stop
  assign start_cond = scl & pin_d_r[0] & ~sda & pin_d_r[1];
  assign stop_cond = scl & pin_d_r[0] & sda & ~pin_d_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  slave_state_t state_r, state_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic read_r, read_nxt;
  logic mack_r, mack_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [7:0] reg_addr_r, reg_addr_nxt;
  logic [7:0] rd_addr_r, rd_addr_nxt;
  logic wr_stb_r, wr_stb_nxt;
  logic rd_stb_nxt;

  // loading a read byte pulses rd_stb; the core answers in the same cycle
  always_comb
  begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    read_nxt = read_r;
    mack_nxt = mack_r;
    oe_n_nxt = oe_n_r;
    reg_addr_nxt = reg_addr_r;
    rd_addr_nxt = rd_addr_r;
    wr_stb_nxt = 1'b0;
    rd_stb_nxt = 1'b0;
    if (!cs || stop_cond)
    begin
      state_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
    end
    else if (start_cond)
    begin
      state_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      oe_n_nxt = 1'b1;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE: ;
        ST_ADDR, ST_REG, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == BITS_PER_BYTE)
          begin
            oe_n_nxt = 1'b0; // acknowledge
            cnt_nxt = 4'h0;
            if (state_r == ST_ADDR)
            begin
              read_nxt = shift_r[0];
              rd_addr_nxt = ADDR_EVENT;
              state_nxt = ST_ACK_ADDR;
              if (shift_r[7:1] != DEV_ADDR)
              begin
                oe_n_nxt = 1'b1; // not ours: stay off the line
                state_nxt = ST_IDLE;
              end
            end
            else if (state_r == ST_REG)
            begin
              reg_addr_nxt = shift_r;
              state_nxt = ST_ACK_REG;
            end
            else
            begin
              wr_stb_nxt = 1'b1;
              state_nxt = ST_ACK_WDATA;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_REG, ST_ACK_WDATA, ST_MASTER_ACK:
        begin
          if (scl_rise && state_r == ST_MASTER_ACK)
            mack_nxt = ~sda;
          else if (scl_fall)
          begin
            oe_n_nxt = 1'b1;
            cnt_nxt = 4'h0;
            unique case (state_r)
              ST_ACK_REG: state_nxt = ST_WDATA;
              ST_ACK_WDATA: state_nxt = ST_IDLE; // one byte per transfer
              default: state_nxt = read_r ? ST_RDATA : ST_REG;
            endcase
            if (state_r == ST_MASTER_ACK && !mack_r)
              state_nxt = ST_IDLE; // master ends the read
            else if (state_nxt == ST_RDATA)
            begin
              rd_stb_nxt = 1'b1;
              oe_n_nxt = port.rd_data[7];
              shift_nxt = {port.rd_data[6:0], 1'b0};
              cnt_nxt = 4'h1;
              rd_addr_nxt = ADDR_STATUS; // later bytes repeat status
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt_r == BITS_PER_BYTE)
            begin
              oe_n_nxt = 1'b1;
              state_nxt = ST_MASTER_ACK;
            end
            else
            begin
              oe_n_nxt = shift_r[7];
              shift_nxt = {shift_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      cnt_r <= 4'h0;
      read_r <= 1'b0;
      mack_r <= 1'b0;
      oe_n_r <= 1'b1;
      reg_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
      wr_stb_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      read_r <= read_nxt;
      mack_r <= mack_nxt;
      oe_n_r <= oe_n_nxt;
      reg_addr_r <= reg_addr_nxt;
      rd_addr_r <= rd_addr_nxt;
      wr_stb_r <= wr_stb_nxt;
    end
  end

  assign sda_oe_n_o = oe_n_r;
  assign port.wr_stb = wr_stb_r;
  assign port.wr_addr = reg_addr_r;
  assign port.wr_data = shift_r;
  assign port.rd_stb = rd_stb_nxt;
  assign port.rd_addr = rd_addr_r;

endmodule : serial_reg_slave

// ===== logic/event_status_and_mask_unit.sv
// event, status and mask unit of a transceiver, with its two-wire register port
// assumes raw condition levels from analog/transmit blocks, asynchronous to clock_i
//
// What this block does
// - read-only event register: bits 0,1,2,3,7 report conditions; 4..6 reserved
// - read-only live status register with the same bit layout
// - bit 1 is 1 when recovered frequency is outside its window
// - bit 2 is 1 when junction temperature indication is at or above threshold
// - bit 3 is 1 when the transmit synthesizer has lost lock
// - bit 7 is 1 once a serializer FIFO over/underflow has occurred
// - write-only mask, 1 unmasks a condition; reset unmasks only temperature
// - a masked condition never drives the interrupt output
// - interrupt config bit 0 inverts output polarity; reset value 01h
`timescale 1ns/10ps
module event_status_and_mask_unit
  import evt_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic cs_i,
  input wire logic signal_lost_i,
  input wire logic freq_out_window_i,
  input wire logic over_temp_i,
  input wire logic synth_unlocked_i,
  input wire logic fifo_slip_i,
  output logic sda_oe_n_o,
  output logic irq_o,
  output logic [CFG_COUNT*8-1:0] config_o
);

  reg_port_if port ();

  serial_reg_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .cs_i(cs_i),
    .sda_oe_n_o(sda_oe_n_o),
    .port(port.slave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // condition synchronisers; conditions come from other domains
  logic [4:0] cond_s1_r;
  logic [4:0] cond_s2_r;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cond_s1_r <= 5'h00;
      cond_s2_r <= 5'h00;
    end
    else
    begin
      cond_s1_r <= {fifo_slip_i, synth_unlocked_i, over_temp_i,
                    freq_out_window_i, signal_lost_i};
      cond_s2_r <= cond_s1_r;
    end
  end

  // live flags in register layout, reserved bits zero
  logic [7:0] live;
  always_comb
  begin
    live = 8'h00;
    live[BIT_SIGNAL_LOST] = cond_s2_r[0];
    live[BIT_FREQ_WINDOW] = cond_s2_r[1];
    live[BIT_OVER_TEMP] = cond_s2_r[2];
    live[BIT_SYNTH_UNLOCKED] = cond_s2_r[3];
    live[BIT_FIFO_SLIP] = cond_s2_r[4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // event, mask and polarity registers
  logic [7:0] event_r, event_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [7:0] irq_conf_r, irq_conf_nxt;
  logic irq_r, irq_nxt;
  logic wr_mask, wr_conf, rd_event;

  assign wr_mask = port.wr_stb && port.wr_addr == ADDR_MASK;
  assign wr_conf = port.wr_stb && port.wr_addr == ADDR_IRQ_CONF;
  assign rd_event = port.rd_stb && port.rd_addr == ADDR_EVENT;

  // event bits are sticky and clear on read; a set in the read cycle wins
  always_comb
  begin
    event_nxt = ((rd_event ? 8'h00 : event_r) | live) & FLAG_BITS;
    status_nxt = live;
    mask_nxt = wr_mask ? (port.wr_data & FLAG_BITS) : mask_r;
    irq_conf_nxt = wr_conf ? port.wr_data : irq_conf_r;
    // only unmasked events reach the pin
    irq_nxt = (|(event_r & mask_r)) ^ irq_conf_r[BIT_IRQ_POLARITY];
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      event_r <= 8'h00;
      status_r <= 8'h00;
      mask_r <= MASK_RESET;
      irq_conf_r <= IRQ_CONF_RESET;
      irq_r <= IRQ_RESET_LEVEL;
    end
    else
    begin
      event_r <= event_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_conf_r <= irq_conf_nxt;
      irq_r <= irq_nxt;
    end
  end

  // read mux; writes to the two read-only offsets fall through unused
  assign port.rd_data = (port.rd_addr == ADDR_EVENT) ? event_r : status_r;
  assign irq_o = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // transmit configuration bytes; range of the divider is left to the master
  logic [7:0] cfg_r [CFG_COUNT];
  logic [7:0] cfg_nxt [CFG_COUNT];

  generate
    for (genvar g = 0; g < CFG_COUNT; g++)
    begin : g_cfg
      always_comb
      begin
        cfg_nxt[g] = (port.wr_stb && port.wr_addr == CFG_ADDR[g]) ? port.wr_data : cfg_r[g];
      end

      always_ff @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
          cfg_r[g] <= CFG_RESET[g];
        else
          cfg_r[g] <= cfg_nxt[g]; // no range check on the main divider
      end

      assign config_o[g*8 +: 8] = cfg_r[g];
    end
  endgenerate

endmodule : event_status_and_mask_unit

// ===== tb/two_wire_master.sv
// behavioural two-wire bus master that reaches the unit's registers
// assumes the data wire is pulled up and resolved outside; it only pulls low
`timescale 1ns/10ps
module two_wire_master
  import evt_pkg::*;
(
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o,
  output logic cs_o
);
  int half = 6; // clocks per scl phase, raised for slow transfers

  // bus idles released with the port selected
  initial
  begin
    scl_o = 1'h1;
    sda_low_o = 1'h0;
    cs_o = 1'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask : tick

  // data changes only while scl is low, read back just before the fall
  task automatic bit_io(input logic b, output logic s);
    sda_low_o = ~b;
    tick(half);
    scl_o = 1'h1;
    tick(half);
    s = sda_i;
    scl_o = 1'h0;
    tick(1);
  endtask : bit_io

  task automatic start();
    tick(half);
    sda_low_o = 1'h1;
    tick(half);
    scl_o = 1'h0;
    tick(1);
  endtask : start

  task automatic stop();
    sda_low_o = 1'h1;
    tick(half);
    scl_o = 1'h1;
    tick(half);
    sda_low_o = 1'h0;
    tick(half);
  endtask : stop

  // msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(mack, ack);
  endtask : xfer

  // one data byte per write transfer
  task automatic write_reg(input logic [7:0] r, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0;
    logic a1;
    logic a2;
    start();
    xfer({DEV_ADDR_DEFAULT, 1'h0}, 1'h1, q, a0);
    xfer(r, 1'h1, q, a1);
    xfer(d, 1'h1, q, a2);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask : write_reg

  // event byte acked, status byte refused to end the read
  task automatic read2(output logic [7:0] ev, output logic [7:0] st);
    logic [7:0] q;
    logic a;
    start();
    xfer({DEV_ADDR_DEFAULT, 1'h1}, 1'h1, q, a);
    xfer(8'hFF, 1'h0, ev, a);
    xfer(8'hFF, 1'h1, st, a);
    stop();
  endtask : read2

  task automatic park(input int n);
    cs_o = 1'h0;
    tick(n);
    cs_o = 1'h1;
  endtask : park
endmodule : two_wire_master

// ===== tb/event_unit_asserts.sv
// pin-level assertions for the event, status and mask unit
// assumes scl idles high and every scl phase lasts at least 6 clocks
`timescale 1ns/10ps
module event_unit_asserts
  import evt_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic cs_i,
  input wire logic over_temp_i,
  input wire logic sda_oe_n_o,
  input wire logic irq_o,
  input wire logic [CFG_COUNT*8-1:0] config_o
);
  logic touched_r;
  logic touched_nxt;
  logic hot_r;
  logic hot_nxt;
  logic [CFG_COUNT*8-1:0] cfg_rst;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////////
  // mask and polarity are known only until the first bus clock
  always_comb
  begin
    touched_nxt = touched_r | (cs_i & ~scl_i);
    hot_nxt = hot_r | over_temp_i;
    for (int g = 0; g < CFG_COUNT; g++)
      cfg_rst[g*8 +: 8] = CFG_RESET[g];
  end

  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      touched_r <= 1'h0;
      hot_r <= 1'h0;
    end
    else
    begin
      touched_r <= touched_nxt;
      hot_r <= hot_nxt;
    end

  ////////////////////////////////////////////////////////////////////////////////
  a_irq_idle_reset: assert property ($fell(rst_i) |-> irq_o)
    else $error("irq not idle after reset");
  a_cfg_reset_vals: assert property ($fell(rst_i) |-> config_o == cfg_rst)
    else $error("config not at reset values");
  a_masked_quiet: assert property (!touched_r && !hot_r |-> irq_o)
    else $error("masked condition raised irq");
  a_temp_raises_irq: assert property (!touched_r && $rose(over_temp_i) |-> ##[3:6] !irq_o)
    else $error("temperature did not raise irq");
  a_event_held: assert property (!touched_r && !irq_o |=> !irq_o || touched_r)
    else $error("event dropped without a read");
  a_ack_on_low: assert property ($fell(sda_oe_n_o) |-> !scl_i)
    else $error("data driven while scl high");
  a_oe_stable_high: assert property (scl_i [*7] |-> $stable(sda_oe_n_o))
    else $error("data changed during scl high");
  a_oe_cs_idle: assert property (!cs_i [*6] |-> sda_oe_n_o)
    else $error("data driven while deselected");

  cover property (!irq_o);
  cover property ($fell(sda_oe_n_o));
  cover property (!cs_i [*6]);
endmodule : event_unit_asserts

bind event_status_and_mask_unit event_unit_asserts i_chk (
  .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .cs_i(cs_i), .over_temp_i(over_temp_i),
  .sda_oe_n_o(sda_oe_n_o), .irq_o(irq_o), .config_o(config_o));

// ===== tb/event_status_and_mask_unit_bench.sv
// self-checking bench for the event, status and mask unit
// assumes the two-wire master model and the pin checker are compiled alongside
`timescale 1ns/10ps
module event_status_and_mask_unit_bench;
  import evt_pkg::*;
  logic clock_i;
  logic rst_i;
  logic [4:0] cond;
  wire logic scl, sda_low, cs, sda_oe_n, irq;
  wire logic [CFG_COUNT*8-1:0] cfg;
  wire logic sda = ~sda_low & sda_oe_n; // pulled up, open drain on both sides
  int fail_count = 0;
  int tests_run = 0;
  logic [7:0] exp_ev, ev, st, m;
  logic [4:0] c;
  logic p, ok;

  two_wire_master i_master (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(sda_low), .cs_o(cs));
  event_status_and_mask_unit i_dut (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda), .cs_i(cs), .signal_lost_i(cond[0]), .freq_out_window_i(cond[1]),
    .over_temp_i(cond[2]), .synth_unlocked_i(cond[3]), .fifo_slip_i(cond[4]),
    .sda_oe_n_o(sda_oe_n), .irq_o(irq), .config_o(cfg));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] flags(input logic [4:0] v);
    return {v[4], 3'h0, v[3:0]};
  endfunction : flags

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask : step

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // held long enough to pass the condition synchronisers
  task automatic apply(input logic [4:0] v);
    cond = v;
    step(8);
    exp_ev = exp_ev | flags(v);
  endtask : apply

  // a read clears the sticky byte, live levels set it again
  task automatic read_check();
    i_master.read2(ev, st);
    check("event", exp_ev, ev);
    check("status", flags(cond), st);
    exp_ev = flags(cond);
  endtask : read_check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial
  begin
    clock_i = 1'h0;
    forever #25 clock_i = ~clock_i;
  end

  // hang guard, well above the longest expected run
  initial
  begin
    repeat (80000) @(posedge clock_i);
    fail_count++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    rst_i = 1'h1;
    cond = 5'h00;
    exp_ev = 8'h00;
    void'($urandom(32'h5B7AE3AB));
    step(16);
    rst_i = 1'h0;
    step(3);
    for (int k = 0; k < 4; k++)
      apply(5'($urandom) & 5'h1B);
    check("irq masked", 8'h01, 8'(irq));
    apply(5'h04);
    apply(5'h00);
    check("irq temp", 8'h00, 8'(irq));
    read_check();
    step(6);
    check("irq cleared", 8'h01, 8'(irq));
    // corner masks first, then random mask, polarity and levels at two bus speeds
    for (int k = 0; k < 8; k++)
    begin
      m = (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : 8'($urandom);
      p = 1'($urandom);
      c = (k < 2) ? 5'h1F : 5'($urandom);
      i_master.half = (k % 2) ? 12 : 6;
      i_master.write_reg(ADDR_MASK, m, ok);
      check("mask ack", 8'h01, 8'(ok));
      i_master.write_reg(ADDR_IRQ_CONF, {7'h00, p}, ok);
      apply(c);
      read_check();
      step(6);
      check("irq", 8'(p ^ (|(flags(c) & m & FLAG_BITS))), 8'(irq));
    end
    m = 8'($urandom) | 8'h80;
    i_master.write_reg(CFG_ADDR[2], m, ok);
    check("divider", m, cfg[23:16]);
    i_master.write_reg(8'h7E, 8'h00, ok);
    check("unmapped", m, cfg[23:16]);
    i_master.write_reg(ADDR_EVENT, 8'hFF, ok);
    read_check();
    i_master.start();
    i_master.xfer({~DEV_ADDR_DEFAULT, 1'h0}, 1'h1, ev, ok);
    i_master.stop();
    check("foreign address", 8'h01, 8'(ok));
    i_master.park(10);
    read_check();
    tally_and_finish();
  end
endmodule : event_status_and_mask_unit_bench
